// ### src/excst_regs.sv
// Exception state registers: code, priority view, nested state, return PC
`timescale 1ns/1ps
`include "excst_map.svh"
module excst_regs
  import excst_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input excst_exc_t excIn,
  input wire logic statusExl,
  input wire logic statusErl,
  input wire logic eicMode,
  input wire logic [7:0] eicLevel,
  input excst_mov_t movIn,
  output logic [31:0] rdData,
  output logic rdValid,
  output logic [31:0] epcOut,
  output logic [1:0] isaMode,
  output logic [1:0] swIntPending,
  output logic [7:0] reqLevel,
  output logic [4:0] exception_code_field,
  output logic branchDelay
);

  // Register select decode
  function automatic logic regHit(
    input logic [4:0] num,
    input logic [2:0] sel,
    input logic [4:0] wantNum,
    input logic [2:0] wantSel
  );
    regHit = (num == wantNum) && (sel == wantSel);
  endfunction

  logic excGen;
  logic excErr;
  logic excDbg;
  logic capture;
  logic hitCause;
  logic hitView;
  logic hitNested;
  logic hitEpc;
  logic mtcEpc;
  logic mtcView;
  logic epcLoad;
  logic [31:0] epcSrc;
  logic [31:0] mtcPcVal;
  logic [31:0] epcLoadData;
  logic [31:0] epcRead;
  logic wrBit0;
  logic excDelay;
  logic [31:0] rdMux;

  logic [4:0] code_r;
  logic [7:0] level_r;
  logic [1:0] ip_r;
  logic prior_error_level_r;
  logic prior_exception_level_r;
  logic bd_r;
  logic [1:0] isa_r;
  logic [31:0] rd_r;
  logic rdValid_r;

  assign excGen = excIn.valid && (excIn.cls == EXCST_CLS_GEN);
  assign excErr = excIn.valid && (excIn.cls == EXCST_CLS_ERR);
  assign excDbg = excIn.valid && (excIn.cls == EXCST_CLS_DBG);
  assign excDelay = excIn.delaySlot;

  assign hitCause = regHit(movIn.num, movIn.sel, `EXCST_NUM_CAUSE, `EXCST_SEL_CAUSE);
  assign hitView = regHit(movIn.num, movIn.sel, `EXCST_NUM_CAUSE, `EXCST_SEL_VIEW);
  assign hitNested = regHit(movIn.num, movIn.sel, `EXCST_NUM_CAUSE, `EXCST_SEL_NESTED);
  assign hitEpc = regHit(movIn.num, movIn.sel, `EXCST_NUM_EPC, `EXCST_SEL_EPC);

  assign mtcEpc = movIn.wrEn && hitEpc;
  assign mtcView = movIn.wrEn && hitView;
  assign wrBit0 = movIn.wrData[0];

  // Capture only outside exception level
  assign capture = excGen && !statusExl;

  // Branch address when in delay slot
  assign epcSrc = excIn.delaySlot ? excIn.branchPc : excIn.pc;

  // Software write clears PC bit 0
  assign mtcPcVal = {movIn.wrData[31:1], 1'b0};

  // Exception beats a concurrent move
  assign epcLoad = capture || mtcEpc;
  assign epcLoadData = capture ? epcSrc : mtcPcVal;

  excst_pc_hold excst_pc_hold_inst
  (
    .sys_clk(sys_clk),
    .load(epcLoad),
    .loadData(epcLoadData),
    .pcOut(epcOut)
  );

  // Exception code of the last general-class exception
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      code_r <= `EXCST_CODE_RST;
    end
    else if (excGen)
    begin
      code_r <= excIn.code;
    end
  end

  // Requested level from the controller
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level_r <= `EXCST_LVL_RST;
    end
    else if (eicMode)
    begin
      level_r <= eicLevel;
    end
    else
    begin
      level_r <= `EXCST_LVL_RST;
    end
  end

  // Software interrupt pending bits
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ip_r <= `EXCST_IP_RST;
    end
    else if (mtcView)
    begin
      ip_r <= movIn.wrData[1:0];
    end
  end

  // Prior error level
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prior_error_level_r <= 1'b0;
    end
    else if (excGen || excErr)
    begin
      prior_error_level_r <= statusErl;
    end
  end

  // Prior exception level
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prior_exception_level_r <= 1'b0;
    end
    else if (excGen)
    begin
      prior_exception_level_r <= statusExl;
    end
  end

  // Delay slot flag
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bd_r <= 1'b0;
    end
    else if (capture)
    begin
      bd_r <= excIn.delaySlot;
    end
  end

  // Instruction set mode bits
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      isa_r <= `EXCST_ISA_RST;
    end
    else if (mtcEpc && !capture)
    begin
      isa_r <= {1'b0, wrBit0};
    end
  end

  // Read value of the return PC
  assign epcRead = {epcOut[31:1], isa_r[0]};

  // Read multiplexer
  always_comb
  begin
    rdMux = `EXCST_RD_RST;
    if (hitCause)
    begin
      rdMux[`EXCST_CODE_MSB:`EXCST_CODE_LSB] = code_r;
      rdMux[`EXCST_CAUSE_LVL_LSB +: 8] = level_r;
      rdMux[`EXCST_CAUSE_IP_LSB +: 2] = ip_r;
      rdMux[`EXCST_CAUSE_BD_BIT] = bd_r;
    end
    else if (hitView)
    begin
      rdMux[`EXCST_VIEW_LVL_MSB:`EXCST_VIEW_LVL_LSB] = level_r;
      rdMux[1:0] = ip_r;
    end
    else if (hitNested)
    begin
      rdMux[`EXCST_NEST_ERL_BIT] = prior_error_level_r;
      rdMux[`EXCST_NEST_EXL_BIT] = prior_exception_level_r;
    end
    else if (hitEpc)
    begin
      rdMux = epcRead;
    end
  end

  // Registered read data
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_r <= `EXCST_RD_RST;
      rdValid_r <= 1'b0;
    end
    else
    begin
      rdValid_r <= movIn.rdEn;
      if (movIn.rdEn)
      begin
        rd_r <= rdMux;
      end
    end
  end

  assign rdData = rd_r;
  assign rdValid = rdValid_r;
  assign isaMode = isa_r;
  assign swIntPending = ip_r;
  assign reqLevel = level_r;
  assign exception_code_field = code_r;
  assign branchDelay = bd_r;

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_code_read;
    movIn.rdEn && hitCause |=> rdData[1:0] == 2'b00 && rdData[6:2] == $past(code_r);
  endproperty
  a_code_read: assert property (p_code_read)
    else $error("cause read code field wrong");

  property p_code_update;
    excGen |=> exception_code_field == $past(excIn.code);
  endproperty
  a_code_update: assert property (p_code_update)
    else $error("exception code not captured");

  property p_view_read;
    movIn.rdEn && hitView |=> rdData[31:10] == 22'h0 && rdData[9:2] == $past(reqLevel);
  endproperty
  a_view_read: assert property (p_view_read)
    else $error("priority view read wrong");

  property p_level_eic;
    eicMode |=> reqLevel == $past(eicLevel);
  endproperty
  a_level_eic: assert property (p_level_eic)
    else $error("level does not follow controller");

  property p_level_off;
    !eicMode [*2] |-> reqLevel == 8'h00;
  endproperty
  a_level_off: assert property (p_level_off)
    else $error("level nonzero outside controller mode");

  property p_ip_write;
    mtcView ##1 !mtcView ##1 movIn.rdEn && hitView && !mtcView
      |=> rdData[1:0] == $past(movIn.wrData[1:0], 3);
  endproperty
  a_ip_write: assert property (p_ip_write)
    else $error("pending bits read back wrong");

  property p_ip_value;
    mtcView |=> swIntPending == $past(movIn.wrData[1:0]);
  endproperty
  a_ip_value: assert property (p_ip_value)
    else $error("pending bits not written");

  property p_nested_zero;
    movIn.rdEn && hitNested |=> rdData[31:3] == 29'h0 && rdData[0] == 1'b0;
  endproperty
  a_nested_zero: assert property (p_nested_zero)
    else $error("nested state spare bits nonzero");

  property p_prior_error_level_update;
    (excGen || excErr) |=> prior_error_level_r == $past(statusErl);
  endproperty
  a_prior_error_level_update: assert property (p_prior_error_level_update)
    else $error("prior error level not captured");

  property p_prior_error_level_debug;
    excDbg |=> $stable(prior_error_level_r);
  endproperty
  a_prior_error_level_debug: assert property (p_prior_error_level_debug)
    else $error("prior error level changed on debug");

  property p_prior_exception_level_update;
    excGen |=> prior_exception_level_r == $past(statusExl);
  endproperty
  a_prior_exception_level_update: assert property (p_prior_exception_level_update)
    else $error("prior exception level not captured");

  property p_prior_exception_level_hold;
    (excErr || excDbg) |=> $stable(prior_exception_level_r);
  endproperty
  a_prior_exception_level_hold: assert property (p_prior_exception_level_hold)
    else $error("prior exception level changed");

  property p_epc_plain;
    capture && !excDelay |=> epcOut == $past(excIn.pc);
  endproperty
  a_epc_plain: assert property (p_epc_plain)
    else $error("return PC not faulting address");

  property p_epc_delay;
    capture && excDelay |=> epcOut == $past(excIn.branchPc) && branchDelay;
  endproperty
  a_epc_delay: assert property (p_epc_delay)
    else $error("return PC not branch address");

  property p_epc_hold;
    excGen && statusExl && !mtcEpc |=> epcOut == $past(epcOut);
  endproperty
  a_epc_hold: assert property (p_epc_hold)
    else $error("return PC captured at exception level");

  property p_epc_read;
    movIn.rdEn && hitEpc |=> rdData == $past(epcRead);
  endproperty
  a_epc_read: assert property (p_epc_read)
    else $error("return PC read wrong");

  property p_epc_write;
    mtcEpc && !capture |=> epcOut == $past({movIn.wrData[31:1], 1'b0}) && epcOut[0] == 1'b0;
  endproperty
  a_epc_write: assert property (p_epc_write)
    else $error("return PC write wrong");

  property p_isa_write;
    mtcEpc && !capture |=> isaMode[1] == 1'b0 && isaMode[0] == $past(wrBit0);
  endproperty
  a_isa_write: assert property (p_isa_write)
    else $error("mode bits not loaded");

  property p_bd_hold;
    excGen && statusExl |=> $stable(branchDelay);
  endproperty
  a_bd_hold: assert property (p_bd_hold)
    else $error("delay flag changed at exception level");

  property p_bd_update;
    excGen && !statusExl |=> branchDelay == $past(excDelay);
  endproperty
  a_bd_update: assert property (p_bd_update)
    else $error("delay flag not captured");

  c_capture_delay: cover property (capture && excDelay);
  c_nested_exc: cover property (excGen && statusExl);
  c_write_then_read: cover property (mtcEpc ##2 movIn.rdEn && hitEpc);
  c_eic_level: cover property (eicMode && eicLevel == 8'hff);

endmodule // excst_regs

// ### src/excst_map.svh
// Register map, field positions and reset values for the exception state registers
`ifndef EXCST_MAP_SVH
`define EXCST_MAP_SVH

`define EXCST_NUM_CAUSE 5'h0d
`define EXCST_NUM_EPC 5'h0e
`define EXCST_SEL_CAUSE 3'h0
`define EXCST_SEL_VIEW 3'h4
`define EXCST_SEL_NESTED 3'h5
`define EXCST_SEL_EPC 3'h0

`define EXCST_CODE_LSB 2
`define EXCST_CODE_MSB 6
`define EXCST_VIEW_LVL_LSB 2
`define EXCST_VIEW_LVL_MSB 9
`define EXCST_CAUSE_LVL_LSB 10
`define EXCST_CAUSE_IP_LSB 8
`define EXCST_CAUSE_BD_BIT 31
`define EXCST_NEST_ERL_BIT 2
`define EXCST_NEST_EXL_BIT 1

`define EXCST_LVL_RST 8'h00
`define EXCST_IP_RST 2'h0
`define EXCST_CODE_RST 5'h00
`define EXCST_ISA_RST 2'h0
`define EXCST_RD_RST 32'h0000_0000

`endif

// ### src/excst_pkg.sv
// Types shared by the exception state register files
package excst_pkg;

  typedef enum logic [2:0]
  {
    EXCST_CLS_GEN = 3'b001,
    EXCST_CLS_ERR = 3'b010,
    EXCST_CLS_DBG = 3'b100
  } excst_cls_t;

  typedef struct packed
  {
    logic valid;
    excst_cls_t cls;
    logic [4:0] code;
    logic [31:0] pc;
    logic delaySlot;
    logic [31:0] branchPc;
  } excst_exc_t;

  typedef struct packed
  {
    logic wrEn;
    logic rdEn;
    logic [4:0] num;
    logic [2:0] sel;
    logic [31:0] wrData;
  } excst_mov_t;

endpackage

// ### src/excst_pc_hold.sv
// Return PC storage word without reset
`timescale 1ns/1ps
module excst_pc_hold
  import excst_pkg::*;
(
  input wire logic sys_clk,
  input wire logic load,
  input wire logic [31:0] loadData,
  output logic [31:0] pcOut
);

  logic [31:0] pc_r;

  // Undefined after reset by design
  always_ff @(posedge sys_clk)
  begin
    if (load)
    begin
      pc_r <= loadData;
    end
  end

  assign pcOut = pc_r;

endmodule // excst_pc_hold

// ### bench/excst_pipe_model.sv
// Pipeline-side model driving exceptions, status flags and controller level
`timescale 1ns/1ps
module excst_pipe_model
  import excst_pkg::*;
(
  input wire logic sys_clk,
  output excst_exc_t excIn,
  output logic statusExl,
  output logic statusErl,
  output logic eicMode,
  output logic [7:0] eicLevel
);
  initial
  begin
    excIn = '0;
    statusExl = 1'b0;
    statusErl = 1'b0;
    eicMode = 1'b0;
    eicLevel = 8'h00;
  end
  // One exception pulse after gap idle cycles; fields scrambled after
  task automatic raise(input excst_cls_t cls, input logic [4:0] code, input logic [31:0] pc,
    input logic ds, input logic [31:0] bpc, input logic exception_level_flag, input logic error_level_flag, input int gap);
    excst_exc_t e;
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    e = '{valid: 1'b1, cls: cls, code: code, pc: pc, delaySlot: ds, branchPc: bpc};
    excIn <= e;
    statusExl <= exception_level_flag;
    statusErl <= error_level_flag;
    @(posedge sys_clk);
    e = excst_exc_t'(~e);
    e.valid = 1'b0;
    excIn <= e;
  endtask
  // Controller mode and pending level
  task automatic level(input logic mode, input logic [7:0] lvl);
    @(posedge sys_clk);
    eicMode <= mode;
    eicLevel <= lvl;
  endtask
endmodule // excst_pipe_model

// ### bench/tb_top.sv
// Testbench for the exception state registers
`timescale 1ns/1ps
`include "excst_map.svh"
module tb_top
  import excst_pkg::*;
;
  logic sysClk;
  logic rstN;
  excst_exc_t excIn;
  logic statusExl;
  logic statusErl;
  logic eicMode;
  logic [7:0] eicLevel;
  excst_mov_t movIn;
  logic [31:0] rdData;
  logic rdValid;
  logic [31:0] epcOut;
  logic [1:0] isaMode;
  logic [1:0] swIntPending;
  logic [7:0] reqLevel;
  logic [4:0] exception_code_field;
  logic branchDelay;
  int n_mismatch;
  int n_checks;

  excst_pipe_model excst_pipe_model_inst (.sys_clk(sysClk), .excIn(excIn),
    .statusExl(statusExl), .statusErl(statusErl), .eicMode(eicMode), .eicLevel(eicLevel));
  excst_regs excst_regs_inst (.sys_clk(sysClk), .rst_n(rstN), .excIn(excIn),
    .statusExl(statusExl), .statusErl(statusErl), .eicMode(eicMode), .eicLevel(eicLevel),
    .movIn(movIn), .rdData(rdData), .rdValid(rdValid), .epcOut(epcOut), .isaMode(isaMode),
    .swIntPending(swIntPending), .reqLevel(reqLevel), .exception_code_field(exception_code_field),
    .branchDelay(branchDelay));

  initial sysClk = 1'b0;
  always #4 sysClk = ~sysClk;

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One move request, held one cycle, then scrambled and idle
  task automatic mov(input logic wr, input logic [4:0] num, input logic [2:0] sel,
    input logic [31:0] d);
    excst_mov_t m;
    @(posedge sysClk);
    m = '{wrEn: wr, rdEn: !wr, num: num, sel: sel, wrData: d};
    movIn <= m;
    @(posedge sysClk);
    m = excst_mov_t'(~m);
    m.wrEn = 1'b0;
    m.rdEn = 1'b0;
    movIn <= m;
    #1;
  endtask

  task automatic rd(input string name, input logic [4:0] num, input logic [2:0] sel,
    input logic [31:0] exp);
    mov(1'b0, num, sel, 32'h0000_0000);
    chk("rdValid", 32'h0000_0001, {31'h0, rdValid});
    chk(name, exp, rdData);
  endtask

  task automatic conclude;
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge sysClk);
    n_mismatch++;
    $display("ERROR timeout expected end seen hang");
    conclude();
  end

  initial
  begin
    n_mismatch = 0;
    n_checks = 0;
    movIn = '0;
    rstN = 1'b0;
    repeat (3) @(posedge sysClk);
    rstN <= 1'b1;
    #1;
    chk("reset outs", 32'h0, {14'h0, isaMode, swIntPending, reqLevel, exception_code_field, branchDelay});
    rd("view rst", `EXCST_NUM_CAUSE, `EXCST_SEL_VIEW, 32'h0000_0000);
    rd("nest rst", `EXCST_NUM_CAUSE, `EXCST_SEL_NESTED, 32'h0000_0000);
    mov(1'b1, `EXCST_NUM_EPC, `EXCST_SEL_EPC, 32'h0000_1235);
    chk("epcOut", 32'h0000_1234, epcOut);
    chk("isaMode", 32'h0000_0001, {30'h0, isaMode});
    rd("epc", `EXCST_NUM_EPC, `EXCST_SEL_EPC, 32'h0000_1235);
    mov(1'b1, `EXCST_NUM_EPC, `EXCST_SEL_EPC, 32'hFFFF_FFFE);
    chk("isaMode", 32'h0000_0000, {30'h0, isaMode});
    rd("epc", `EXCST_NUM_EPC, `EXCST_SEL_EPC, 32'hFFFF_FFFE);
    mov(1'b1, `EXCST_NUM_CAUSE, `EXCST_SEL_VIEW, 32'hFFFF_FFFF);
    chk("swInt", 32'h0000_0003, {30'h0, swIntPending});
    rd("view", `EXCST_NUM_CAUSE, `EXCST_SEL_VIEW, 32'h0000_0003);
    excst_pipe_model_inst.level(1'b1, 8'hA5);
    rd("view", `EXCST_NUM_CAUSE, `EXCST_SEL_VIEW, 32'h0000_0297);
    chk("reqLevel", 32'h0000_00A5, {24'h0, reqLevel});
    excst_pipe_model_inst.level(1'b1, 8'hFF);
    rd("view", `EXCST_NUM_CAUSE, `EXCST_SEL_VIEW, 32'h0000_03FF);
    excst_pipe_model_inst.level(1'b0, 8'h5A);
    @(posedge sysClk);
    #1;
    chk("reqLevel", 32'h0000_0000, {24'h0, reqLevel});
    mov(1'b1, `EXCST_NUM_CAUSE, `EXCST_SEL_VIEW, 32'h0000_0001);
    chk("swInt", 32'h0000_0001, {30'h0, swIntPending});
    // Delay slot exception, level clear
    excst_pipe_model_inst.raise(EXCST_CLS_GEN, 5'h0C, 32'h8000_0100, 1'b1, 32'h8000_00FC,
      1'b0, 1'b1, 0);
    #1;
    chk("epcOut", 32'h8000_00FC, epcOut);
    chk("bd", 32'h0000_0001, {31'h0, branchDelay});
    rd("nest", `EXCST_NUM_CAUSE, `EXCST_SEL_NESTED, 32'h0000_0004);
    rd("cause", `EXCST_NUM_CAUSE, `EXCST_SEL_CAUSE, 32'h8000_0130);
    excst_pipe_model_inst.raise(EXCST_CLS_GEN, 5'h0D, 32'h8000_0200, 1'b0, 32'h8000_01FC,
      1'b0, 1'b0, 2);
    #1;
    chk("epcOut", 32'h8000_0200, epcOut);
    chk("bd", 32'h0000_0000, {31'h0, branchDelay});
    // Nested exception with level set
    excst_pipe_model_inst.raise(EXCST_CLS_GEN, 5'h04, 32'h8000_0300, 1'b1, 32'h8000_02FC,
      1'b1, 1'b0, 0);
    #1;
    chk("epcOut", 32'h8000_0200, epcOut);
    chk("bd", 32'h0000_0000, {31'h0, branchDelay});
    chk("exception_code_field", 32'h0000_0004, {27'h0, exception_code_field});
    rd("nest", `EXCST_NUM_CAUSE, `EXCST_SEL_NESTED, 32'h0000_0002);
    excst_pipe_model_inst.raise(EXCST_CLS_ERR, 5'h1F, 32'h8000_0400, 1'b0, 32'h8000_03FC,
      1'b0, 1'b1, 0);
    #1;
    chk("epcOut", 32'h8000_0200, epcOut);
    chk("exception_code_field", 32'h0000_0004, {27'h0, exception_code_field});
    rd("nest", `EXCST_NUM_CAUSE, `EXCST_SEL_NESTED, 32'h0000_0006);
    excst_pipe_model_inst.raise(EXCST_CLS_DBG, 5'h1E, 32'h8000_0500, 1'b0, 32'h8000_04FC,
      1'b1, 1'b0, 0);
    #1;
    rd("nest", `EXCST_NUM_CAUSE, `EXCST_SEL_NESTED, 32'h0000_0006);
    mov(1'b1, `EXCST_NUM_CAUSE, `EXCST_SEL_NESTED, 32'hFFFF_FFFF);
    rd("nest", `EXCST_NUM_CAUSE, `EXCST_SEL_NESTED, 32'h0000_0006);
    mov(1'b1, `EXCST_NUM_EPC, `EXCST_SEL_EPC, 32'h0000_0777);
    rd("epc", `EXCST_NUM_EPC, `EXCST_SEL_EPC, 32'h0000_0777);
    conclude();
  end
endmodule // tb_top
